// ===== aexs_defines.svh
`ifndef AEXS_DEFINES_SVH
`define AEXS_DEFINES_SVH
// What this block does
// RULE_01: Subtract-borrow immediate, 0x94, A = A-C-imm
// RULE_02: Borrow sets carry, aux carry, overflow flags
// RULE_03: Nibble swap of accumulator, flags untouched
// RULE_04: Byte exchange swaps accumulator and operand
// RULE_05: Byte exchange register, direct, indirect encodings
// RULE_06: Digit exchange swaps low nibbles only
// RULE_07: Exclusive-or writes destination, flags untouched
// RULE_08: Six exclusive-or operand combinations supported
// RULE_09: Port destination reads output latch, not pins
// RULE_10: Accumulator exclusive-or register/direct/indirect encodings
// RULE_11: Exclusive-or immediate to accumulator, one cycle
// RULE_12: Exclusive-or accumulator into direct byte
// RULE_13: Exclusive-or immediate into direct, two cycles
// RULE_14: Low opcode bits select working or index register

// ****************************************
// Opcode encodings (full bytes or high bits)
// ****************************************
`define AEXS_OPC_SUB_BORROW_IMM 8'h94
`define AEXS_OPC_NIB_SWAP 8'hc4
`define AEXS_OPC_EXCH_REG 5'h19
`define AEXS_OPC_EXCH_DIR 8'hc5
`define AEXS_OPC_EXCH_IND 7'h63
`define AEXS_OPC_DIGIT_IND 7'h6b
`define AEXS_OPC_XOR_REG 5'h0d
`define AEXS_OPC_XOR_DIR 8'h65
`define AEXS_OPC_XOR_IND 7'h33
`define AEXS_OPC_XOR_IMM 8'h64
`define AEXS_OPC_XOR_DA 8'h62
`define AEXS_OPC_XOR_DI 8'h63

// ****************************************
// Address map of direct space
// ****************************************
`define AEXS_ACC_ADDR 8'he0
`define AEXS_PORT0_ADDR 8'h80
`define AEXS_PORT1_ADDR 8'h90
`define AEXS_PORT2_ADDR 8'ha0
`define AEXS_PORT3_ADDR 8'hb0

// ****************************************
// Reset values
// ****************************************
`define AEXS_ACC_RST 8'h00
`define AEXS_FLAG_RST 1'b0
`endif

// ===== aexs_pkg.sv
package aexs_pkg;
    // Operation classes of this slice
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SUB_BORROW,
        OP_NIB_SWAP,
        OP_BYTE_EXCH,
        OP_DIGIT_EXCH,
        OP_XOR
    } aexs_op_e;
    // Where the operand lives
    typedef enum logic [2:0] {
        MD_NONE,
        MD_REG,
        MD_DIR,
        MD_IND,
        MD_IMM
    } aexs_src_e;
    // Execution sequencer
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_OPER
    } aexs_state_e;
    // Subtract result with its three flags
    typedef struct packed {
        logic [7:0] res;
        logic cy;
        logic aux;
        logic ovf;
    } aexs_subtract_with_borrow_s;
endpackage

// ===== aexs_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "aexs_defines.svh"
module aexs_decode import aexs_pkg::*; (
    input wire logic [7:0] opcode_in,
    output var aexs_op_e op_out,
    output var aexs_src_e src_out,
    output logic dst_dir_out,
    output logic mask_imm_out,
    output logic two_cyc_out
);
    // ****************************************
    // Opcode classification
    // ****************************************
    // If-chain, since register forms carry operand bits in the opcode
    always_comb begin
        op_out = OP_NONE;
        src_out = MD_NONE;
        dst_dir_out = 1'b0;
        mask_imm_out = 1'b0;
        two_cyc_out = 1'b0;
        if (opcode_in == `AEXS_OPC_SUB_BORROW_IMM) begin // RULE_01
            op_out = OP_SUB_BORROW;
            src_out = MD_IMM;
        end else if (opcode_in == `AEXS_OPC_NIB_SWAP) begin // RULE_03
            op_out = OP_NIB_SWAP;
        end else if (opcode_in[7:3] == `AEXS_OPC_EXCH_REG) begin // RULE_05
            op_out = OP_BYTE_EXCH;
            src_out = MD_REG;
        end else if (opcode_in == `AEXS_OPC_EXCH_DIR) begin // RULE_05
            op_out = OP_BYTE_EXCH;
            src_out = MD_DIR;
        end else if (opcode_in[7:1] == `AEXS_OPC_EXCH_IND) begin // RULE_05
            op_out = OP_BYTE_EXCH;
            src_out = MD_IND;
        end else if (opcode_in[7:1] == `AEXS_OPC_DIGIT_IND) begin // RULE_06
            op_out = OP_DIGIT_EXCH;
            src_out = MD_IND;
        end else if (opcode_in[7:3] == `AEXS_OPC_XOR_REG) begin // RULE_10
            op_out = OP_XOR;
            src_out = MD_REG;
        end else if (opcode_in == `AEXS_OPC_XOR_DIR) begin // RULE_10
            op_out = OP_XOR;
            src_out = MD_DIR;
        end else if (opcode_in[7:1] == `AEXS_OPC_XOR_IND) begin // RULE_10
            op_out = OP_XOR;
            src_out = MD_IND;
        end else if (opcode_in == `AEXS_OPC_XOR_IMM) begin // RULE_11
            op_out = OP_XOR;
            src_out = MD_IMM;
        end else if (opcode_in == `AEXS_OPC_XOR_DA) begin // RULE_12
            op_out = OP_XOR;
            src_out = MD_DIR;
            dst_dir_out = 1'b1;
        end else if (opcode_in == `AEXS_OPC_XOR_DI) begin // RULE_13
            op_out = OP_XOR;
            src_out = MD_DIR;
            dst_dir_out = 1'b1;
            mask_imm_out = 1'b1;
            two_cyc_out = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== aexs_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "aexs_defines.svh"
module aexs_exec import aexs_pkg::*; (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic ISSUE_IN,
    input wire logic [7:0] OPCODE_IN,
    input wire logic [7:0] BYTE2_IN,
    input wire logic [7:0] BYTE3_IN,
    input wire logic [1:0] BANK_SEL_IN,
    input wire logic [7:0] SFR_RDATA_IN,
    input wire logic [7:0] SFR_LATCH_IN,
    input wire logic LOAD_ACC_IN,
    input wire logic [7:0] LOAD_ACC_DATA_IN,
    input wire logic LOAD_FLAGS_IN,
    input wire logic [2:0] LOAD_FLAGS_DATA_IN,
    input wire logic RAM_WE_IN,
    input wire logic [7:0] RAM_ADDR_IN,
    input wire logic [7:0] RAM_WDATA_IN,
    output logic BUSY_OUT,
    output logic DONE_OUT,
    output logic REJECT_OUT,
    output logic [7:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic AUX_CARRY_OUT,
    output logic OVERFLOW_OUT,
    output logic [7:0] RAM_RDATA_OUT,
    output logic [7:0] SFR_ADDR_OUT,
    output logic SFR_RD_OUT,
    output logic SFR_WE_OUT,
    output logic [7:0] SFR_WDATA_OUT
);
    // ****************************************
    // Declarations
    // ****************************************
    aexs_state_e state_reg; // Sequencer
    aexs_op_e op_reg; // Captured operation
    aexs_src_e src_reg; // Captured operand mode
    aexs_op_e dec_op; // Decoder outputs
    aexs_src_e dec_src;
    logic dec_dst_dir, dec_mask_imm, dec_two_cyc;
    logic dst_dir_reg; // Result goes to direct byte
    logic mask_imm_reg; // Mask from third byte
    logic [7:0] addr_reg; // Operand location
    logic [7:0] imm_reg; // Second instruction byte
    logic [7:0] mask_byte_reg; // Third instruction byte
    logic loc_sfr_reg; // Operand is outside register
    logic loc_acc_reg; // Operand is accumulator itself
    logic loc_port_reg; // Operand is an output port
    logic [7:0] acc_reg; // Accumulator
    logic cy_reg, aux_reg, ovf_reg; // Flags
    logic [7:0] ram [0:255]; // Internal RAM, banks at bottom
    logic accept; // Issue taken this cycle
    logic exec; // Result cycle
    logic [7:0] iss_addr; // Operand address at issue
    logic iss_sfr, iss_acc;
    logic [7:0] opnd; // Operand value in result cycle
    logic [7:0] mask; // Exclusive-or mask
    aexs_subtract_with_borrow_s subtract_with_borrow; // Subtract result
    logic acc_we, loc_we;
    logic [7:0] acc_next, loc_data;

    // ****************************************
    // Helpers
    // ****************************************
    // Borrow chain from three widths gives all flags
    function automatic aexs_subtract_with_borrow_s sub_borrow(input logic [7:0] a, input logic [7:0] b,
                                              input logic c);
        aexs_subtract_with_borrow_s r;
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] mid;
        full = {1'b0, a} - {1'b0, b} - {8'h00, c};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        mid = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, c};
        r.res = full[7:0];
        r.cy = full[8];
        r.aux = low[4];
        r.ovf = full[8] ^ mid[7];
        return r;
    endfunction
    // Output ports, read from the latch when an exclusive-or writes them
    function automatic logic is_port(input logic [7:0] a);
        return (a == `AEXS_PORT0_ADDR) || (a == `AEXS_PORT1_ADDR) ||
               (a == `AEXS_PORT2_ADDR) || (a == `AEXS_PORT3_ADDR);
    endfunction
    // Opcode classifier, purely combinational
    aexs_decode u_decode (.opcode_in(OPCODE_IN), .op_out(dec_op), .src_out(dec_src),
        .dst_dir_out(dec_dst_dir), .mask_imm_out(dec_mask_imm), .two_cyc_out(dec_two_cyc));

    // ****************************************
    // Issue stage
    // ****************************************
    assign accept = ISSUE_IN && (state_reg == ST_IDLE);
    assign exec = (state_reg == ST_OPER);
    assign iss_acc = (dec_src == MD_DIR) && (BYTE2_IN == `AEXS_ACC_ADDR);
    // Upper half of direct space, accumulator aside, is outside this block
    assign iss_sfr = (dec_src == MD_DIR) && BYTE2_IN[7] && !iss_acc;
    // Operand address from mode
    always_comb begin
        iss_addr = 8'h00;
        unique case (dec_src)
            MD_REG: iss_addr = {3'b000, BANK_SEL_IN, OPCODE_IN[2:0]}; // RULE_14
            MD_DIR: iss_addr = BYTE2_IN;
            // Pointer may reach the whole RAM, upper half included
            MD_IND: iss_addr = ram[{3'b000, BANK_SEL_IN, 2'b00, OPCODE_IN[0]}]; // RULE_14
            MD_NONE, MD_IMM: iss_addr = 8'h00;
        endcase
    end

    // Sequencer: one result cycle, an extra wait for the three-byte form
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept && dec_op != OP_NONE) begin
                        state_reg <= dec_two_cyc ? ST_WAIT : ST_OPER; // RULE_13
                    end
                end
                ST_WAIT: state_reg <= ST_OPER;
                ST_OPER: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Capture of the instruction at issue
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            op_reg <= OP_NONE;
            src_reg <= MD_NONE;
            dst_dir_reg <= 1'b0;
            mask_imm_reg <= 1'b0;
            addr_reg <= 8'h00;
            imm_reg <= 8'h00;
            mask_byte_reg <= 8'h00;
            loc_sfr_reg <= 1'b0;
            loc_acc_reg <= 1'b0;
            loc_port_reg <= 1'b0;
        end else if (accept) begin
            op_reg <= dec_op;
            src_reg <= dec_src;
            dst_dir_reg <= dec_dst_dir;
            mask_imm_reg <= dec_mask_imm;
            addr_reg <= iss_addr;
            imm_reg <= BYTE2_IN;
            mask_byte_reg <= BYTE3_IN;
            loc_sfr_reg <= iss_sfr;
            loc_acc_reg <= iss_acc;
            loc_port_reg <= iss_sfr && is_port(BYTE2_IN);
        end
    end

    // ****************************************
    // Result stage
    // ****************************************
    // Operand fetch; port read-modify-write takes the latch
    always_comb begin
        if (src_reg == MD_IMM) begin
            opnd = imm_reg;
        end else if (loc_acc_reg) begin
            opnd = acc_reg;
        end else if (loc_sfr_reg) begin
            // Pins may be loaded low externally; latch keeps intent
            opnd = (op_reg == OP_XOR && dst_dir_reg && loc_port_reg) ?
                   SFR_LATCH_IN : SFR_RDATA_IN; // RULE_09
        end else begin
            opnd = ram[addr_reg];
        end
    end

    assign mask = mask_imm_reg ? mask_byte_reg : acc_reg; // RULE_08
    assign subtract_with_borrow = sub_borrow(acc_reg, opnd, cy_reg); // RULE_01
    // Destination values per operation
    always_comb begin
        acc_we = 1'b0;
        loc_we = 1'b0;
        acc_next = acc_reg;
        loc_data = 8'h00;
        unique case (op_reg)
            OP_SUB_BORROW: begin
                acc_we = 1'b1;
                acc_next = subtract_with_borrow.res; // RULE_01
            end
            OP_NIB_SWAP: begin
                acc_we = 1'b1;
                acc_next = {acc_reg[3:0], acc_reg[7:4]}; // RULE_03
            end
            OP_BYTE_EXCH: begin
                // Both sides written in the same edge, nothing lost
                acc_we = 1'b1;
                acc_next = opnd; // RULE_04
                loc_we = 1'b1;
                loc_data = acc_reg; // RULE_04
            end
            OP_DIGIT_EXCH: begin
                acc_we = 1'b1;
                acc_next = {acc_reg[7:4], opnd[3:0]}; // RULE_06
                loc_we = 1'b1;
                loc_data = {opnd[7:4], acc_reg[3:0]}; // RULE_06
            end
            OP_XOR: begin
                if (dst_dir_reg) begin
                    loc_we = 1'b1;
                    loc_data = opnd ^ mask; // RULE_12
                end else begin
                    acc_we = 1'b1;
                    acc_next = acc_reg ^ opnd; // RULE_07
                end
            end
            OP_NONE: acc_we = 1'b0;
        endcase
    end

    // Accumulator; exchange write wins over direct write to itself
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            acc_reg <= `AEXS_ACC_RST;
        end else if (exec && acc_we) begin
            acc_reg <= acc_next;
        end else if (exec && loc_we && loc_acc_reg) begin
            acc_reg <= loc_data;
        end else if (state_reg == ST_IDLE && LOAD_ACC_IN) begin
            acc_reg <= LOAD_ACC_DATA_IN;
        end
    end

    // Flags change only on subtract or on a flag load while idle
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cy_reg <= `AEXS_FLAG_RST;
            aux_reg <= `AEXS_FLAG_RST;
            ovf_reg <= `AEXS_FLAG_RST;
        end else if (exec && op_reg == OP_SUB_BORROW) begin
            cy_reg <= subtract_with_borrow.cy; // RULE_02
            aux_reg <= subtract_with_borrow.aux; // RULE_02
            ovf_reg <= subtract_with_borrow.ovf; // RULE_02
        end else if (state_reg == ST_IDLE && LOAD_FLAGS_IN) begin
            {cy_reg, aux_reg, ovf_reg} <= LOAD_FLAGS_DATA_IN;
        end
    end

    // Internal RAM; no reset, contents are software's
    always_ff @(posedge CLK_SYS_IN) begin
        if (exec && loc_we && !loc_sfr_reg && !loc_acc_reg) begin
            ram[addr_reg] <= loc_data;
        end else if (state_reg == ST_IDLE && RAM_WE_IN) begin
            ram[RAM_ADDR_IN] <= RAM_WDATA_IN;
        end
    end

    // ****************************************
    // Outside registers and handshake
    // ****************************************
    // External register access: address held from issue to result
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            SFR_ADDR_OUT <= 8'h00;
            SFR_RD_OUT <= 1'b0;
            SFR_WE_OUT <= 1'b0;
            SFR_WDATA_OUT <= 8'h00;
        end else begin
            if (accept && dec_op != OP_NONE) begin
                SFR_ADDR_OUT <= iss_addr;
                SFR_RD_OUT <= iss_sfr;
            end else if (exec) begin
                SFR_RD_OUT <= 1'b0;
            end
            SFR_WE_OUT <= exec && loc_we && loc_sfr_reg;
            if (exec && loc_we && loc_sfr_reg) begin
                SFR_WDATA_OUT <= loc_data;
            end
        end
    end

    // Handshake and visible state
    always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            REJECT_OUT <= 1'b0;
            RAM_RDATA_OUT <= 8'h00;
        end else begin
            // Set on take, dropped on the result edge
            BUSY_OUT <= (accept && dec_op != OP_NONE) || (BUSY_OUT && !exec);
            DONE_OUT <= exec;
            // Opcodes of other slices are refused, not executed
            REJECT_OUT <= accept && dec_op == OP_NONE;
            RAM_RDATA_OUT <= ram[RAM_ADDR_IN];
        end
    end

    // Flag and accumulator views straight from their flops
    assign ACC_OUT = acc_reg;
    assign CARRY_OUT = cy_reg;
    assign AUX_CARRY_OUT = aux_reg;
    assign OVERFLOW_OUT = ovf_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    sub_result_a: assert property ((exec && op_reg == OP_SUB_BORROW) |=> // RULE_01
        ACC_OUT == 8'($past(acc_reg) - $past(opnd) - {7'h00, $past(cy_reg)}))
        else $error("subtract result wrong");
    sub_carry_a: assert property ((exec && op_reg == OP_SUB_BORROW) |=> // RULE_02
        CARRY_OUT == ({1'b0, $past(acc_reg)} < ({1'b0, $past(opnd)} + {8'h00, $past(cy_reg)})))
        else $error("subtract borrow wrong");
    swap_nibble_a: assert property ((exec && op_reg == OP_NIB_SWAP) |=> // RULE_03
        ACC_OUT == {$past(acc_reg[3:0]), $past(acc_reg[7:4])} && $stable(CARRY_OUT))
        else $error("nibble swap wrong");
    exch_ram_a: assert property ((exec && op_reg == OP_BYTE_EXCH && !loc_sfr_reg // RULE_04
        && !loc_acc_reg) |=> ACC_OUT == $past(opnd) && ram[$past(addr_reg)] == $past(acc_reg))
        else $error("byte exchange lost a value");
    digit_exch_a: assert property ((exec && op_reg == OP_DIGIT_EXCH) |=> // RULE_06
        ACC_OUT[7:4] == $past(acc_reg[7:4]) && ram[$past(addr_reg)][3:0] == $past(acc_reg[3:0]))
        else $error("digit exchange wrong");
    xor_flags_a: assert property ((exec && op_reg == OP_XOR) |=> // RULE_07
        $stable({CARRY_OUT, AUX_CARRY_OUT, OVERFLOW_OUT})) else $error("xor touched flags");
    port_latch_a: assert property ((exec && op_reg == OP_XOR && dst_dir_reg && // RULE_09
        loc_port_reg) |=> SFR_WE_OUT && SFR_WDATA_OUT == ($past(SFR_LATCH_IN) ^ $past(mask)))
        else $error("port not read from latch");
    one_cycle_a: assert property ((accept && dec_op != OP_NONE && !dec_two_cyc) |-> // RULE_10
        ##1 !DONE_OUT ##1 DONE_OUT) else $error("one-cycle form late");
    two_cycle_a: assert property ((accept && dec_two_cyc) |-> // RULE_13
        ##1 !DONE_OUT [*2] ##1 DONE_OUT) else $error("two-cycle form timing wrong");
    reg_select_a: assert property ((accept && dec_src == MD_REG) |=> // RULE_14
        addr_reg == {3'b000, $past(BANK_SEL_IN), $past(OPCODE_IN[2:0])})
        else $error("working register select wrong");
    sub_seen_c: cover property (exec && op_reg == OP_SUB_BORROW && subtract_with_borrow.ovf);
    xor_imm_c: cover property (exec && op_reg == OP_XOR && mask_imm_reg);
    digit_seen_c: cover property (exec && op_reg == OP_DIGIT_EXCH);
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top import aexs_pkg::*;;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk_sys = 1'b0; // Core clock, 4 ns period
    logic rst_n = 1'b0; // Asynchronous reset, held low at start
    logic issue = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] byte2 = 8'h00;
    logic [7:0] byte3 = 8'h00;
    logic [1:0] bank = 2'h0;
    logic [7:0] sfr_pins = 8'hff; // Pins differ from latch on purpose
    logic [7:0] sfr_latch = 8'h34;
    logic ld_acc = 1'b0;
    logic [7:0] ld_acc_data = 8'h00;
    logic ld_flg = 1'b0;
    logic [2:0] ld_flg_data = 3'h0;
    logic ram_we = 1'b0;
    logic [7:0] ram_addr = 8'h00;
    logic [7:0] ram_wdata = 8'h00;
    logic busy, done, reject, cy, aux, ovf, sfr_rd, sfr_we;
    logic [7:0] acc, ram_rdata, sfr_addr, sfr_wdata;
    int n_errors = 0; // Mismatches
    int checked = 0; // Comparisons made
    int cycles = 0; // Watchdog count
    int base_lat; // Latency of a one-cycle form
    logic we_seen, rd_seen, bz_seen; // Captured during one instruction
    logic [7:0] wd_seen;
    logic [7:0] rv; // RAM read-back

    always #2 clk_sys = ~clk_sys;

    aexs_exec dut (.CLK_SYS_IN(clk_sys), .RESET_N_IN(rst_n), .ISSUE_IN(issue),
        .OPCODE_IN(opcode), .BYTE2_IN(byte2), .BYTE3_IN(byte3), .BANK_SEL_IN(bank),
        .SFR_RDATA_IN(sfr_pins), .SFR_LATCH_IN(sfr_latch), .LOAD_ACC_IN(ld_acc),
        .LOAD_ACC_DATA_IN(ld_acc_data), .LOAD_FLAGS_IN(ld_flg),
        .LOAD_FLAGS_DATA_IN(ld_flg_data), .RAM_WE_IN(ram_we), .RAM_ADDR_IN(ram_addr),
        .RAM_WDATA_IN(ram_wdata), .BUSY_OUT(busy), .DONE_OUT(done), .REJECT_OUT(reject),
        .ACC_OUT(acc), .CARRY_OUT(cy), .AUX_CARRY_OUT(aux), .OVERFLOW_OUT(ovf),
        .RAM_RDATA_OUT(ram_rdata), .SFR_ADDR_OUT(sfr_addr), .SFR_RD_OUT(sfr_rd),
        .SFR_WE_OUT(sfr_we), .SFR_WDATA_OUT(sfr_wdata));

    // ****************************************
    // Shared bus tasks
    // ****************************************
    // Load accumulator and flags together while idle
    task automatic ld(input logic [7:0] a, input logic [2:0] f);
        @(posedge clk_sys);
        ld_acc <= 1'b1; ld_acc_data <= a; ld_flg <= 1'b1; ld_flg_data <= f;
        @(posedge clk_sys);
        ld_acc <= 1'b0; ld_flg <= 1'b0;
    endtask
    // Write one RAM byte; starts on a fresh edge so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        ram_we <= 1'b1; ram_addr <= a; ram_wdata <= d;
        @(posedge clk_sys);
        ram_we <= 1'b0;
    endtask
    // Read back one RAM byte, data lands one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        ram_addr <= a;
        @(posedge clk_sys);
        @(posedge clk_sys);
        #1 d = ram_rdata;
    endtask
    // Issue one instruction, count edges after the take edge to the answer
    task automatic exec(input logic [7:0] op, b2, b3, output int n);
        n = 0; we_seen = 1'b0; rd_seen = 1'b0; wd_seen = 8'h00;
        @(posedge clk_sys);
        issue <= 1'b1; opcode <= op; byte2 <= b2; byte3 <= b3;
        @(posedge clk_sys);
        issue <= 1'b0;
        #1;
        bz_seen = busy;
        while (done !== 1'b1 && reject !== 1'b1 && n < 10) begin
            if (sfr_rd === 1'b1) rd_seen = 1'b1;
            @(posedge clk_sys);
            n++;
            #1;
        end
        // Write pulse stands in the same cycle as the answer
        if (sfr_we === 1'b1) begin
            we_seen = 1'b1; wd_seen = sfr_wdata;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Subtract with borrow: borrow into and out of bit 7 in turn
    task automatic t_subtract_with_borrow();
        logic [7:0] va [3] = '{8'hc9, 8'h00, 8'h80};
        logic [2:0] vc [3] = '{3'b100, 3'b000, 3'b000};
        logic [7:0] vi [3] = '{8'h54, 8'h01, 8'h01};
        logic [7:0] vr [3] = '{8'h74, 8'hff, 8'h7f};
        logic [2:0] vf [3] = '{3'b001, 3'b110, 3'b011};
        int n;
        for (int k = 0; k < 3; k++) begin
            ld(va[k], vc[k]);
            exec(8'h94, vi[k], 8'h00, n);
            if (k == 0) base_lat = n;
            `CHK("subtract_with_borrow lat", base_lat, n)
            `CHK("subtract_with_borrow acc", vr[k], acc)
            `CHK("subtract_with_borrow flags", vf[k], {cy, aux, ovf})
        end
    endtask
    // Nibble swap keeps all flags
    task automatic t_swap();
        int n;
        ld(8'hc5, 3'b101);
        exec(8'hc4, 8'h00, 8'h00, n);
        `CHK("swap lat", base_lat, n)
        `CHK("swap acc", 8'h5c, acc)
        `CHK("swap flags", 3'b101, {cy, aux, ovf})
        `CHK("swap busy", 1'b1, bz_seen)
        `CHK("swap free", 1'b0, busy)
    endtask
    // Byte exchange in register, direct and indirect forms
    task automatic t_xch();
        int n;
        @(posedge clk_sys) bank <= 2'h1;
        wr(8'h0b, 8'h75);
        ld(8'h3f, 3'b000);
        exec(8'hcb, 8'h00, 8'h00, n);
        `CHK("xch reg lat", base_lat, n)
        `CHK("xch reg acc", 8'h75, acc)
        rd(8'h0b, rv);
        `CHK("xch reg ram", 8'h3f, rv)
        wr(8'h30, 8'h11);
        exec(8'hc5, 8'h30, 8'h00, n);
        `CHK("xch dir acc", 8'h11, acc)
        rd(8'h30, rv);
        `CHK("xch dir ram", 8'h75, rv)
        @(posedge clk_sys) bank <= 2'h0;
        wr(8'h01, 8'h20);
        wr(8'h20, 8'h5a);
        exec(8'hc7, 8'h00, 8'h00, n);
        `CHK("xch ind acc", 8'h5a, acc)
        rd(8'h20, rv);
        `CHK("xch ind ram", 8'h11, rv)
    endtask
    // Digit exchange swaps only the low nibbles
    task automatic t_digit_exchange();
        int n;
        @(posedge clk_sys) bank <= 2'h2;
        wr(8'h10, 8'h20);
        wr(8'h20, 8'h75);
        ld(8'h36, 3'b111);
        exec(8'hd6, 8'h00, 8'h00, n);
        `CHK("digit_exchange lat", base_lat, n)
        `CHK("digit_exchange acc", 8'h35, acc)
        `CHK("digit_exchange flags", 3'b111, {cy, aux, ovf})
        rd(8'h20, rv);
        `CHK("digit_exchange ram", 8'h76, rv)
    endtask
    // Accumulator destination in all four source forms, then direct with A
    task automatic t_xor();
        int n;
        @(posedge clk_sys) bank <= 2'h3;
        wr(8'h18, 8'haa);
        wr(8'h19, 8'h41);
        wr(8'h41, 8'hff);
        ld(8'hc3, 3'b110);
        exec(8'h68, 8'h00, 8'h00, n);
        `CHK("xor reg acc", 8'h69, acc)
        exec(8'h64, 8'h0f, 8'h00, n);
        `CHK("xor imm lat", base_lat, n)
        `CHK("xor imm acc", 8'h66, acc)
        exec(8'h65, 8'h41, 8'h00, n);
        `CHK("xor dir acc", 8'h99, acc)
        exec(8'h67, 8'h00, 8'h00, n);
        `CHK("xor ind acc", 8'h66, acc)
        `CHK("xor flags", 3'b110, {cy, aux, ovf})
        exec(8'h62, 8'h41, 8'h00, n);
        `CHK("xor da acc", 8'h66, acc)
        rd(8'h41, rv);
        `CHK("xor da ram", 8'h99, rv)
    endtask
    // Port destination uses the output latch; a port source reads the pins
    task automatic t_port();
        int n;
        exec(8'h63, 8'h90, 8'h31, n);
        `CHK("xor di lat", base_lat + 1, n)
        `CHK("xor di addr", 8'h90, sfr_addr)
        `CHK("xor di read", 1'b1, rd_seen)
        `CHK("xor di we", 1'b1, we_seen)
        `CHK("xor di data", 8'h05, wd_seen)
        exec(8'h62, 8'h90, 8'h00, n);
        `CHK("xor pa data", 8'h52, wd_seen)
        `CHK("xor pa lat", base_lat, n)
        exec(8'h65, 8'h90, 8'h00, n);
        `CHK("xor pin acc", 8'h99, acc)
        `CHK("xor pin read", 1'b1, rd_seen)
        `CHK("xor pin we", 1'b0, we_seen)
    endtask
    // Opcode outside this slice is refused without touching state
    task automatic t_rej();
        int n;
        exec(8'h00, 8'h00, 8'h00, n);
        `CHK("rej pulse", 1'b1, reject)
        `CHK("rej lat", base_lat - 1, n)
        `CHK("rej acc", 8'h99, acc)
    endtask

    // ****************************************
    // Verdict and watchdog
    // ****************************************
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        `CHK("rst acc", 8'h00, acc)
        `CHK("rst flags", 3'b000, {cy, aux, ovf})
        t_subtract_with_borrow();
        t_swap();
        t_xch();
        t_digit_exchange();
        t_xor();
        t_port();
        t_rej();
        report_and_stop();
    end
endmodule
`default_nettype wire
